// ==== rtl/spt_tracker.sv ====
// top of the shaft position tracker: registers, zeroing, revolutions
`timescale 1ns/1ps
`default_nettype none

module spt_tracker #(
  parameter int unsigned REV_W = spt_pkg::REV_WIDTH         // revolution counter width
) (
  input  wire logic        mclk,                            // system clock, 200 MHz
  input  wire logic        rstn,                            // async reset, active low
  input  wire logic        enc_step,                        // one decoded encoder step
  input  wire logic        enc_dir,                         // 1 forward, 0 backward
  input  wire logic        enc_index,                       // index pulse, one cycle
  input  wire logic [7:0]  reg_addr,                        // register byte address
  input  wire logic [31:0] reg_wdata,                       // register write data
  input  wire logic        reg_wr,                          // write strobe
  input  wire logic        reg_rd,                          // read strobe
  output logic      [31:0] reg_rdata,                       // read data, next cycle
  output logic             irq                              // level interrupt
);

  // ==========================================================
  // helper functions

  // widen a field into a bus word with zeros above
  function automatic logic [31:0] spt_pad15(input logic [14:0] v);
    spt_pad15 = {17'h00000, v};
  endfunction : spt_pad15

  // match a bus access against one offset
  function automatic logic spt_hit(input logic [7:0] a, input logic [7:0] ofs);
    spt_hit = (a == ofs);
  endfunction : spt_hit

  // ==========================================================
  // declarations

  spt_track_if trk ();                                      // link to the accumulator

  logic                    enc_on_q;                        // encoder-on setting
  logic                    enc_on_d;                        // next encoder-on
  spt_pkg::spt_zsel_type   zsel_q;                          // zero selector
  spt_pkg::spt_zsel_type   zsel_d;                          // next zero selector
  logic signed [REV_W-1:0] revs_q;                          // revolution count
  logic signed [REV_W-1:0] revs_d;                          // next revolution count
  logic                    seen_q;                          // index-seen flag
  logic                    seen_d;                          // next index-seen flag
  logic [31:0]             rdata_q;                         // read data register
  logic [31:0]             rdata_d;                         // next read data
  logic [spt_pkg::IRQ_COUNT-1:0] irq_status;                // sticky event bits
  logic [spt_pkg::IRQ_COUNT-1:0] irq_mask;                  // event enable bits
  logic [spt_pkg::IRQ_COUNT-1:0] irq_events;                // event pulses

  // ==========================================================
  // register address decode

  wire wr_ctrl  = reg_wr & spt_hit(reg_addr, spt_pkg::OFS_CTRL);
  wire wr_cmd   = reg_wr & spt_hit(reg_addr, spt_pkg::OFS_CMD);
  wire wr_istat = reg_wr & spt_hit(reg_addr, spt_pkg::OFS_IRQ_STAT);
  wire wr_imask = reg_wr & spt_hit(reg_addr, spt_pkg::OFS_IRQ_MASK);

  // new control values carried by a write to the control register
  wire       new_enc_on = reg_wdata[spt_pkg::CTRL_ENC_ON_BIT];
  wire [1:0] new_sel    = reg_wdata[spt_pkg::CTRL_SEL_LSB +: 2];

  // ==========================================================
  // zeroing sources

  // index zeroing only under selector 1
  wire zero_by_index = enc_index & (zsel_q == spt_pkg::SPT_SEL_INDEX);

  // software zeroing only under selector 2
  wire zero_by_cmd   = wr_cmd & reg_wdata[spt_pkg::CMD_ZERO_BIT]
                       & (zsel_q == spt_pkg::SPT_SEL_SOFT);

  // any change of encoder-on, either direction
  wire zero_by_enc   = wr_ctrl & (new_enc_on != enc_on_q);

  // all sources merge; zeroing beats a step in the same cycle
  wire zero_any      = zero_by_index | zero_by_cmd | zero_by_enc;

  // ==========================================================
  // drive the accumulator

  // steps count only while the encoder is switched on
  assign trk.step = enc_step & enc_on_q;
  assign trk.dir  = enc_dir;
  assign trk.zero = zero_any;

  // modulo 32768 accumulation lives in the counter
  spt_angle_counter u_angle (
    .mclk (mclk),
    .rstn (rstn),
    .trk  (trk.counter)
  );

  // ==========================================================
  // control register next values

  // control holds its value except on a write to its offset
  always_comb begin
    enc_on_d = enc_on_q;
    zsel_d   = zsel_q;
    if (wr_ctrl) begin
      enc_on_d = new_enc_on;
      zsel_d   = spt_pkg::spt_zsel_type'(new_sel);
    end
  end

  // control storage; the selector comes up as index zeroing
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      enc_on_q <= spt_pkg::ENC_ON_RESET;
      zsel_q   <= spt_pkg::spt_zsel_type'(spt_pkg::SEL_RESET);
    end else begin
      enc_on_q <= enc_on_d;
      zsel_q   <= zsel_d;
    end
  end

  // ==========================================================
  // revolution counter

  // zeroing the angle leaves the turn count alone, since only the
  // wraps are counted; a forward and a backward wrap never meet
  always_comb begin
    revs_d = revs_q;
    if (trk.wrap_fwd) begin
      revs_d = revs_q + REV_W'(1);
    end else if (trk.wrap_bwd) begin
      revs_d = revs_q - REV_W'(1);
    end
  end

  // signed count, two's complement rolls over at its limits
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) revs_q <= REV_W'(spt_pkg::REV_RESET);
    else       revs_q <= revs_d;
  end

  // ==========================================================
  // index-seen flag

  // the reference is lost when a command or encoder toggle zeroes the angle
  // with no index in the same cycle, because the zero is then arbitrary
  always_comb begin
    seen_d = seen_q;
    // set only by a real index under selector 1
    if (zero_by_index) begin
      seen_d = 1'b1;
    end else if (zero_by_cmd | zero_by_enc) begin
      seen_d = 1'b0;
    end
  end

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) seen_q <= spt_pkg::SEEN_RESET;
    else       seen_q <= seen_d;
  end

  // ==========================================================
  // interrupt events

  // reference gained is the rising edge of the flag
  assign irq_events[spt_pkg::IRQ_WRAP_FWD] = trk.wrap_fwd;
  assign irq_events[spt_pkg::IRQ_WRAP_BWD] = trk.wrap_bwd;
  assign irq_events[spt_pkg::IRQ_ZEROED]   = zero_any;
  assign irq_events[spt_pkg::IRQ_REF]      = seen_d & ~seen_q;

  // sticky status, mask and the single level output
  spt_irq #(
    .N (spt_pkg::IRQ_COUNT)
  ) u_irq (
    .mclk    (mclk),
    .rstn    (rstn),
    .events  (irq_events),
    .clr_wr  (wr_istat),
    .mask_wr (wr_imask),
    .wdata   (reg_wdata[spt_pkg::IRQ_COUNT-1:0]),
    .status  (irq_status),
    .mask    (irq_mask),
    .irq     (irq)
  );

  // ==========================================================
  // read data selection

  // values seen by a read are those before any same-cycle update;
  // the command register reads as zero, unmapped offsets read zero
  always_comb begin
    rdata_d = 32'h0000_0000;
    if (reg_rd) begin
      unique case (reg_addr)
        spt_pkg::OFS_CTRL: begin
          rdata_d[spt_pkg::CTRL_ENC_ON_BIT]    = enc_on_q;
          rdata_d[spt_pkg::CTRL_SEL_LSB +: 2]  = zsel_q;
        end
        spt_pkg::OFS_ANGLE: begin
          rdata_d = spt_pad15(trk.angle);
        end
        spt_pkg::OFS_REVS: begin
          // sign extended so software sees a plain signed word
          rdata_d = 32'(revs_q);
        end
        spt_pkg::OFS_STATUS: begin
          // flag tells whether the angle is referenced
          rdata_d[spt_pkg::STAT_SEEN_BIT] = seen_q;
        end
        spt_pkg::OFS_IRQ_STAT: begin
          rdata_d[spt_pkg::IRQ_COUNT-1:0] = irq_status;
        end
        spt_pkg::OFS_IRQ_MASK: begin
          rdata_d[spt_pkg::IRQ_COUNT-1:0] = irq_mask;
        end
        default: begin
          rdata_d = 32'h0000_0000;
        end
      endcase
    end
  end

  // read data stand for the one cycle after the strobe, zero otherwise
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) rdata_q <= 32'h0000_0000;
    else       rdata_q <= rdata_d;
  end

  assign reg_rdata = rdata_q;

endmodule : spt_tracker
`default_nettype wire

// ==== rtl/spt_pkg.sv ====
// shared constants and types of the shaft position tracker
package spt_pkg;

  // ==========================================================
  // angle and revolution geometry
  localparam int unsigned ANGLE_WIDTH = 15;                 // bits of one turn
  localparam int unsigned ANGLE_STEPS = 32768;              // steps per 360 degrees
  localparam logic [14:0] ANGLE_MAX   = 15'h7fff;           // last step before wrap
  localparam logic [14:0] ANGLE_RESET = 15'h0000;           // power-up reference zero
  localparam int unsigned REV_WIDTH   = 32;                 // revolution counter width
  localparam int unsigned DATA_WIDTH  = 32;                 // register bus data width
  localparam int unsigned ADDR_WIDTH  = 8;                  // register bus byte address

  // ==========================================================
  // register offsets (byte addresses)
  localparam logic [7:0] OFS_CTRL     = 8'h00;              // encoder on, zero selector
  localparam logic [7:0] OFS_CMD      = 8'h04;              // angle-zero command
  localparam logic [7:0] OFS_ANGLE    = 8'h08;              // shaft angle, read only
  localparam logic [7:0] OFS_REVS     = 8'h0c;              // revolution count, read only
  localparam logic [7:0] OFS_STATUS   = 8'h10;              // index seen, read only
  localparam logic [7:0] OFS_IRQ_STAT = 8'h14;              // sticky events, write one to clear
  localparam logic [7:0] OFS_IRQ_MASK = 8'h18;              // event enables

  // ==========================================================
  // field positions and reset values
  localparam int unsigned CTRL_ENC_ON_BIT = 0;              // encoder-on setting
  localparam int unsigned CTRL_SEL_LSB    = 1;              // zero selector, two bits
  localparam int unsigned CMD_ZERO_BIT    = 0;              // angle-zero command
  localparam int unsigned STAT_SEEN_BIT   = 0;              // index-seen flag
  localparam logic        ENC_ON_RESET    = 1'b0;           // encoder off after reset
  localparam logic [1:0]  SEL_RESET       = 2'h1;           // index zeroing after reset
  localparam logic        SEEN_RESET      = 1'b0;           // not detected after reset
  localparam logic [31:0] REV_RESET       = 32'h0000_0000;  // revolutions after reset

  // ==========================================================
  // interrupt event bits
  localparam int unsigned IRQ_COUNT    = 4;                 // number of events
  localparam int unsigned IRQ_WRAP_FWD = 0;                 // forward wrap
  localparam int unsigned IRQ_WRAP_BWD = 1;                 // backward wrap
  localparam int unsigned IRQ_ZEROED   = 2;                 // angle was zeroed
  localparam int unsigned IRQ_REF      = 3;                 // index reference gained
  localparam logic [3:0]  IRQ_RESET    = 4'h0;              // status and mask reset

  // zero selector codes
  typedef enum logic [1:0] {
    SPT_SEL_NONE  = 2'b00,                                  // no index or command zeroing
    SPT_SEL_INDEX = 2'b01,                                  // zero on index pulse
    SPT_SEL_SOFT  = 2'b10,                                  // zero on software command
    SPT_SEL_RSVD  = 2'b11                                   // behaves as none
  } spt_zsel_type;

endpackage : spt_pkg

// ==== rtl/spt_track_if.sv ====
// link between the tracker control and its angle accumulator
`timescale 1ns/1ps
`default_nettype none
interface spt_track_if;
  logic        step;                                        // one encoder step
  logic        dir;                                         // 1 forward, 0 backward
  logic        zero;                                        // clear angle this cycle
  logic [14:0] angle;                                       // current shaft angle
  logic        wrap_fwd;                                    // pulse, 32767 to 0
  logic        wrap_bwd;                                    // pulse, 0 to 32767
  modport ctrl (output step, output dir, output zero,
                input angle, input wrap_fwd, input wrap_bwd);
  modport counter (input step, input dir, input zero,
                   output angle, output wrap_fwd, output wrap_bwd);
endinterface : spt_track_if
`default_nettype wire

// ==== rtl/spt_angle_counter.sv ====
// modulo-32768 shaft angle accumulator with wrap detection
`timescale 1ns/1ps
`default_nettype none
module spt_angle_counter (
  input  wire logic         mclk,                           // system clock
  input  wire logic         rstn,                           // async reset, active low
  spt_track_if.counter      trk                             // step in, angle out
);

  logic [14:0] angle_q;                                     // held angle
  logic [14:0] angle_d;                                     // next angle
  wire         at_max = (angle_q == spt_pkg::ANGLE_MAX);    // top of the turn
  wire         at_min = (angle_q == spt_pkg::ANGLE_RESET);  // bottom of the turn

  // ==========================================================
  // wrap events; a zeroing step is not a wrap
  assign trk.wrap_fwd = trk.step & trk.dir & at_max & ~trk.zero;
  assign trk.wrap_bwd = trk.step & ~trk.dir & at_min & ~trk.zero;

  // ==========================================================
  // next angle; natural 15-bit overflow gives the modulo
  always_comb begin
    angle_d = angle_q;
    if (trk.zero) begin
      angle_d = spt_pkg::ANGLE_RESET;
    end else if (trk.step) begin
      angle_d = trk.dir ? 15'(angle_q + 15'h0001) : 15'(angle_q - 15'h0001);
    end
  end

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) angle_q <= spt_pkg::ANGLE_RESET;
    else       angle_q <= angle_d;
  end

  assign trk.angle = angle_q;

endmodule : spt_angle_counter
`default_nettype wire

// ==== rtl/spt_irq.sv ====
// sticky event status with mask and one level interrupt
`timescale 1ns/1ps
`default_nettype none
module spt_irq #(
  parameter int unsigned N = 4                              // number of events
) (
  input  wire logic         mclk,                           // system clock
  input  wire logic         rstn,                           // async reset, active low
  input  wire logic [N-1:0] events,                         // one-cycle event pulses
  input  wire logic         clr_wr,                         // write to status
  input  wire logic         mask_wr,                        // write to mask
  input  wire logic [N-1:0] wdata,                          // write data
  output logic      [N-1:0] status,                         // sticky bits
  output logic      [N-1:0] mask,                           // enable bits
  output logic              irq                             // level interrupt
);

  logic [N-1:0] stat_q;                                     // sticky status
  logic [N-1:0] mask_q;                                     // mask register
  // a new event beats a write-one-to-clear in the same cycle
  wire  [N-1:0] stat_d = (stat_q & ~(clr_wr ? wdata : '0)) | events;

  // ==========================================================
  // status and mask storage
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      stat_q <= '0;
      mask_q <= '0;
    end else begin
      stat_q <= stat_d;
      if (mask_wr) mask_q <= wdata;
    end
  end

  assign status = stat_q;
  assign mask   = mask_q;
  assign irq    = |(stat_q & mask_q);

endmodule : spt_irq
`default_nettype wire

// ==== tb/spt_encoder_model.sv ====
// behavioural incremental encoder with index pulse
`timescale 1ns/1ps
`default_nettype none
module spt_encoder_model (
  input  wire logic mclk,  // system clock
  output logic      step,  // one step pulse
  output logic      dir,   // 1 forward
  output logic      index  // index pulse
);
  // ==========================================================
  // idle levels at time zero
  initial begin
    step  = 1'b0;
    dir   = 1'b0;
    index = 1'b0;
  end

  // n steps; gap 0 gives back-to-back steps, dir toggles while idle
  task move(input int n, input bit fwd, input int gap);
    for (int i = 0; i < n; i++) begin
      @(posedge mclk);
      step <= 1'b1;
      dir  <= fwd;
      for (int j = 0; j < gap; j++) begin
        @(posedge mclk);
        step <= 1'b0;
        dir  <= ~fwd ^ j[0];
      end
    end
    @(posedge mclk);
    step <= 1'b0;
    dir  <= ~fwd;
  endtask : move

  // one-cycle index pulse
  task pulse_index;
    @(posedge mclk);
    index <= 1'b1;
    @(posedge mclk);
    index <= 1'b0;
  endtask : pulse_index
endmodule : spt_encoder_model
`default_nettype wire

// ==== tb/spt_tracker_assertions.sv ====
// port-level assertion checker for the shaft position tracker
`timescale 1ns/1ps
`default_nettype none
module spt_tracker_checker (
  input wire logic        mclk,
  input wire logic        rstn,
  input wire logic        enc_step,
  input wire logic        enc_dir,
  input wire logic        enc_index,
  input wire logic [7:0]  reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic        reg_wr,
  input wire logic        reg_rd,
  input wire logic [31:0] reg_rdata,
  input wire logic        irq
);
  // ==========================================================
  // shadow of control settings seen at the ports
  logic [1:0] sel_q;     // selector copy
  logic       enc_on_q;  // encoder-on copy
  logic       fresh_q;   // nothing happened since reset
  logic       ref_q;     // index seen under selector 1
  wire        ctrl_wr = reg_wr && reg_addr == spt_pkg::OFS_CTRL;
  wire        cmd_wr  = reg_wr && reg_addr == spt_pkg::OFS_CMD;
  wire        rd_ang  = reg_rd && reg_addr == spt_pkg::OFS_ANGLE;
  wire        rd_stat = reg_rd && reg_addr == spt_pkg::OFS_STATUS;
  wire        rd_revs = reg_rd && reg_addr == spt_pkg::OFS_REVS;

  // shadow registers follow writes and index pulses
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      sel_q    <= 2'h1;
      enc_on_q <= 1'b0;
      fresh_q  <= 1'b1;
      ref_q    <= 1'b0;
    end else begin
      if (ctrl_wr) begin
        sel_q    <= reg_wdata[2:1];
        enc_on_q <= reg_wdata[0];
      end
      if (reg_wr || enc_step || enc_index) fresh_q <= 1'b0;
      if (enc_index && sel_q == 2'h1) ref_q <= 1'b1;
    end
  end

  // ==========================================================
  // properties
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rstn);

  a_angle_fits_turn: assert property (
    $past(rd_ang) |-> reg_rdata[31:15] == 17'h0) else $error("angle above one turn");
  a_reset_angle_zero: assert property (
    $past(rd_ang && fresh_q) |-> reg_rdata == 32'h0) else $error("angle not zero");
  a_index_zeroes_angle: assert property (
    enc_index && sel_q == 2'h1 ##1 !enc_step ##1 rd_ang |=> reg_rdata == 32'h0)
    else $error("index did not zero angle");
  a_cmd_zeroes_angle: assert property (
    cmd_wr && reg_wdata[0] && sel_q == 2'h2 ##1 !enc_step ##1 rd_ang |=> reg_rdata == 32'h0)
    else $error("command did not zero angle");
  a_toggle_zeroes_angle: assert property (
    ctrl_wr && reg_wdata[0] != enc_on_q ##1 !enc_step ##1 rd_ang |=> reg_rdata == 32'h0)
    else $error("encoder toggle did not zero angle");
  a_reset_revs_zero: assert property (
    $past(rd_revs && fresh_q) |-> reg_rdata == 32'h0) else $error("revs not zero");
  a_status_one_bit: assert property (
    $past(rd_stat) |-> reg_rdata[31:1] == 31'h0) else $error("status spare bits set");
  a_reset_seen_low: assert property (
    $past(rd_stat && fresh_q) |-> reg_rdata == 32'h0) else $error("flag set after reset");
  a_seen_needs_index: assert property (
    $past(rd_stat && !ref_q) |-> reg_rdata == 32'h0) else $error("flag set without index");
endmodule : spt_tracker_checker
bind spt_tracker spt_tracker_checker spt_tracker_checker_i (.mclk(mclk), .rstn(rstn),
  .enc_step(enc_step), .enc_dir(enc_dir), .enc_index(enc_index), .reg_addr(reg_addr),
  .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .irq(irq));
`default_nettype wire

// ==== tb/tb.sv ====
// self-checking testbench of the shaft position tracker
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin samples_checked++; if ((g) !== (e)) begin n_errors++; \
  $display("mismatch at %0t: got %h expected %h", $time, g, e); end end
module tb;
  // ==========================================================
  // clock, bus and encoder wires
  logic mclk, rstn, reg_wr, reg_rd, irq, step, dir, index;
  logic [7:0]  reg_addr;
  logic [31:0] reg_wdata, reg_rdata;
  int n_errors, samples_checked;
  // reference model state
  int m_angle, m_revs;
  logic [3:0] m_stat, m_mask;
  logic [1:0] m_sel;
  bit m_on, m_seen;

  spt_tracker spt_tracker_i (.mclk(mclk), .rstn(rstn), .enc_step(step), .enc_dir(dir),
    .enc_index(index), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .irq(irq));
  spt_encoder_model spt_encoder_model_i (.mclk(mclk), .step(step), .dir(dir), .index(index));

  // 200 MHz clock
  initial begin
    mclk = 1'b0;
    forever #2.5 mclk = ~mclk;
  end

  // ==========================================================
  // bus tasks: one-cycle strobes, read data checked in the next cycle and checked zero the cycle after
  task wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge mclk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge mclk);
    reg_wr <= 1'b0;
  endtask : wr
  task rd(input logic [7:0] a, input logic [31:0] e);
    @(posedge mclk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge mclk);
    reg_rd <= 1'b0;
    #1 `CHK(reg_rdata, e)
    @(posedge mclk);
    #1 `CHK(reg_rdata, 32'h0)
  endtask : rd

  // ==========================================================
  // model updates beside each stimulus
  task zero(input bit lose);
    m_angle = 0;
    m_stat[2] = 1'b1;
    if (lose) m_seen = 1'b0;
  endtask : zero
  task steps(input int n, input bit fwd, input int gap);
    spt_encoder_model_i.move(n, fwd, gap);
    for (int i = 0; i < n && m_on; i++) begin
      // wrap counting both ways
      if (fwd && m_angle == 32767) begin
        m_revs++;
        m_stat[0] = 1'b1;
      end
      if (!fwd && m_angle == 0) begin
        m_revs--;
        m_stat[1] = 1'b1;
      end
      m_angle = (m_angle + (fwd ? 1 : 32767)) % 32768;
    end
  endtask : steps
  task ctrl(input logic [2:0] v);
    wr(spt_pkg::OFS_CTRL, {29'h0, v});
    if (v[0] != m_on) zero(1'b1);
    m_on = v[0];
    m_sel = v[2:1];
  endtask : ctrl
  task cmd;
    wr(spt_pkg::OFS_CMD, 32'h1);
    if (m_sel == 2'h2) zero(1'b1);
  endtask : cmd
  task idx;
    spt_encoder_model_i.pulse_index;
    if (m_sel == 2'h1) begin
      zero(1'b0);
      if (!m_seen) m_stat[3] = 1'b1;
      m_seen = 1'b1;
    end
  endtask : idx
  task w1c(input logic [3:0] v);
    wr(spt_pkg::OFS_IRQ_STAT, {28'h0, v});
    m_stat &= ~v;
  endtask : w1c
  // compare every visible result with the model
  task check_all;
    rd(spt_pkg::OFS_ANGLE, 32'(m_angle));
    rd(spt_pkg::OFS_REVS, 32'(m_revs));
    rd(spt_pkg::OFS_STATUS, {31'h0, m_seen});
    rd(spt_pkg::OFS_IRQ_STAT, {28'h0, m_stat});
    rd(spt_pkg::OFS_CTRL, {29'h0, m_sel, m_on});
    rd(spt_pkg::OFS_IRQ_MASK, {28'h0, m_mask});
    `CHK(irq, |(m_stat & m_mask))
  endtask : check_all

  // verdict, reached from the main sequence or the watchdog
  task close_out;
    $display("n_errors=%0d samples_checked=%0d", n_errors, samples_checked);
    if (n_errors == 0 && samples_checked > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : close_out

  // watchdog, far beyond the expected run
  initial begin
    repeat (40000) @(posedge mclk);
    n_errors++;
    close_out;
  end

  // ==========================================================
  // main sequence
  initial begin
    {rstn, reg_wr, reg_rd, reg_addr, reg_wdata} = '0;
    {m_angle, m_revs, m_stat, m_mask, m_on, m_seen} = '0;
    m_sel = 2'h1;
    void'($urandom(71));
    repeat (2) @(posedge mclk);
    rstn <= 1'b1;
    check_all;
    rd(spt_pkg::OFS_CTRL, 32'h2);
    rd(8'h40, 32'h0);
    steps(5, 1'b1, 0);
    ctrl(3'h3);
    wr(spt_pkg::OFS_IRQ_MASK, 32'hf);
    m_mask = 4'hf;
    check_all;
    w1c(4'hf);
    steps(1, 1'b0, 0);
    check_all;
    steps(2, 1'b1, 1);
    wr(spt_pkg::OFS_ANGLE, 32'h5);
    check_all;
    for (int k = 0; k < 6; k++) begin
      steps($urandom_range(1, 60), $urandom_range(0, 1), $urandom_range(0, 2));
      check_all;
    end
    idx;
    check_all;
    w1c(4'hf);
    wr(spt_pkg::OFS_IRQ_MASK, 32'h1);
    m_mask = 4'h1;
    steps(3, 1'b1, 0);
    idx;
    check_all;
    ctrl(3'h5);
    steps(3, 1'b1, 0);
    idx;
    check_all;
    cmd;
    check_all;
    for (int s = 0; s < 4; s++) begin
      ctrl({s[1:0], 1'b1});
      steps(4, 1'b0, 0);
      cmd;
      idx;
      check_all;
    end
    ctrl(3'h2);
    // read the angle two cycles after the toggle, as the checker expects
    check_all;
    steps(2, 1'b1, 0);
    check_all;
    close_out;
  end
endmodule : tb
`default_nettype wire
